// ==== verilog/uirq_core.sv ====
// Our own choices: the address map and the APB register port.
`include "uirq_regs.svh"
`default_nettype none
module uirq_core
   import uirq_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = `UIRQ_IDLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [29:0] ep_flags,
   input wire logic bus_activity,
   input wire logic bus_resume,
   input wire logic bus_sof,
   input wire logic bus_reset_done,
   output logic irq,
   output logic suspend_mode
);

   // ==========================================
   // Pin synchronisers: 0 activity, 1 resume, 2 sof, 3 reset end
   logic [3:0] pin_w;
   logic [3:0] s1_r, s2_r, s3_r, lvl_r;
   logic [3:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt;
   logic [3:0] agree, rise;

   assign pin_w = {bus_reset_done, bus_sof, bus_resume, bus_activity};

   // A change only counts once stages two and three agree
   always_comb begin
      s1_nxt = pin_w;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      agree = ~(s2_r ^ s3_r);
      lvl_nxt = (agree & s2_r) | (~agree & lvl_r);
      rise = agree & s2_r & ~lvl_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
         lvl_r <= 4'h0;
      end else if (ce) begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   // ==========================================
   // Endpoint status follows the endpoint flags, no storage here
   logic [`UIRQ_EP_NUM-1:0] ep_sts;
   genvar e;
   generate
      for (e = 0; e < `UIRQ_EP_NUM; e++) begin : g_ep
         // Only the flag owner can drop this bit
         assign ep_sts[e] = |ep_flags[`UIRQ_EP_FLAGS*e +: `UIRQ_EP_FLAGS];
      end
   endgenerate

   // ==========================================
   // Idle timer and suspend state
   uirq_state_e st_r, st_nxt;
   logic [`UIRQ_CNT_W-1:0] idle_r, idle_nxt;
   logic susp_evt;

   // Counter restarts on any stable activity
   always_comb begin
      st_nxt = st_r;
      idle_nxt = idle_r;
      susp_evt = 1'b0;
      case (st_r)
         UIRQ_ACTIVE: begin
            if (lvl_r[0]) begin
               idle_nxt = '0;
            end else if (idle_r == `UIRQ_CNT_W'(IDLE_CYCLES - 1)) begin
               idle_nxt = '0;
               susp_evt = 1'b1;
               st_nxt = UIRQ_SUSPENDED;
            end else begin
               idle_nxt = idle_r + `UIRQ_CNT_W'(1);
            end
         end
         UIRQ_SUSPENDED: begin
            if (lvl_r[0]) begin
               st_nxt = UIRQ_ACTIVE;
            end
         end
         default: st_nxt = UIRQ_ACTIVE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= UIRQ_ACTIVE;
         idle_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
         idle_r <= idle_nxt;
      end
   end

   assign suspend_mode = (st_r == UIRQ_SUSPENDED);

   // ==========================================
   // APB decode; zero wait states while enabled
   logic setup, acc, wr;
   logic sel_en, sel_dis, sel_mask, sel_pend, sel_clr, hit;

   assign setup = psel & ~penable;
   assign acc = psel & penable & ce;
   assign wr = acc & pwrite;

   always_comb begin
      sel_en = 1'b0;
      sel_dis = 1'b0;
      sel_mask = 1'b0;
      sel_pend = 1'b0;
      sel_clr = 1'b0;
      if (paddr == `UIRQ_OFS_ENABLE) begin
         sel_en = 1'b1;
      end else if (paddr == `UIRQ_OFS_DISABLE) begin
         sel_dis = 1'b1;
      end else if (paddr == `UIRQ_OFS_MASK) begin
         sel_mask = 1'b1;
      end else if (paddr == `UIRQ_OFS_PEND) begin
         sel_pend = 1'b1;
      end else if (paddr == `UIRQ_OFS_CLEAR) begin
         sel_clr = 1'b1;
      end
   end

   assign hit = sel_en | sel_dis | sel_mask | sel_pend | sel_clr;
   // Clock enable low stretches the access phase
   assign pready = ce;
   assign pslverr = psel & penable & ~hit;

   // ==========================================
   // Mask and sticky event status
   uirq_word_t mask_r, mask_nxt, pend_r, pend_nxt;
   uirq_word_t en_w, dis_w, clr_w, set_w;
   uirq_word_t mask_view, pend_view;

   always_comb begin
      en_w = (wr & sel_en) ? (pwdata & `UIRQ_MASK_VALID) : '0;
      dis_w = (wr & sel_dis) ? pwdata : '0;
      clr_w = (wr & sel_clr) ? (pwdata & `UIRQ_EVT_VALID) : '0;
      set_w = '0;
      set_w[`UIRQ_BIT_SUSP] = susp_evt;
      set_w[`UIRQ_BIT_RSM] = rise[1];
      set_w[`UIRQ_BIT_SOF] = rise[2];
      set_w[`UIRQ_BIT_BRST] = rise[3];
      set_w[`UIRQ_BIT_WAKE] = rise[1] | rise[3];
      // Zeros written change nothing
      mask_nxt = (mask_r | en_w) & ~dis_w;
      // A new event wins over a clear in the same cycle
      pend_nxt = (pend_r & ~clr_w) | set_w;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= `UIRQ_MASK_RST;
         pend_r <= `UIRQ_PEND_RST;
      end else if (ce) begin
         mask_r <= mask_nxt;
         pend_r <= pend_nxt;
      end
   end

   // End-of-reset source cannot be masked
   assign mask_view = mask_r | `UIRQ_MASK_FORCED;
   assign pend_view = pend_r | {26'h0, ep_sts};
   assign irq = |(pend_view & mask_view);

   // ==========================================
   // Read data, captured in the setup cycle
   uirq_word_t rd_r, rd_nxt;

   always_comb begin
      rd_nxt = rd_r;
      if (setup & ~pwrite) begin
         if (sel_mask) begin
            rd_nxt = mask_view;
         end else if (sel_pend) begin
            rd_nxt = pend_view;
         end else begin
            rd_nxt = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_r <= '0;
      end else if (ce) begin
         rd_r <= rd_nxt;
      end
   end

   assign prdata = rd_r;

   // ==========================================
   // Checks
   property p_dis_clears;
      @(posedge pclk) disable iff (!presetn)
      (wr && sel_dis && pwdata[`UIRQ_BIT_RSM]) |=> !mask_r[`UIRQ_BIT_RSM];
   endproperty
   a_dis_clears: assert property (p_dis_clears)
      else $error("disable write left resume mask set");

   property p_en_sets;
      @(posedge pclk) disable iff (!presetn)
      (wr && sel_en && pwdata[0]) |=> mask_r[0] && (irq || !pend_view[0]);
   endproperty
   a_en_sets: assert property (p_en_sets)
      else $error("enable write did not set mask");

   property p_mask_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && ce && !pwrite && sel_mask) |=>
         prdata[12] && prdata[31:14] == 18'h0 && prdata[7:6] == 2'h0;
   endproperty
   a_mask_read: assert property (p_mask_read)
      else $error("mask read layout wrong");

   property p_ep_irq;
      @(posedge pclk) disable iff (!presetn)
      (ep_flags[4:0] != 5'h0 && mask_r[0]) |-> irq;
   endproperty
   a_ep_irq: assert property (p_ep_irq)
      else $error("endpoint flag did not raise irq");

   property p_susp;
      @(posedge pclk) disable iff (!presetn)
      (ce && st_r == UIRQ_ACTIVE && !lvl_r[0] &&
       idle_r == `UIRQ_CNT_W'(IDLE_CYCLES - 1)) |=>
         pend_r[`UIRQ_BIT_SUSP] && suspend_mode;
   endproperty
   a_susp: assert property (p_susp)
      else $error("idle timeout did not suspend");

   property p_rsm;
      @(posedge pclk) disable iff (!presetn)
      (ce && rise[1]) |=> pend_r[`UIRQ_BIT_RSM] && pend_r[`UIRQ_BIT_WAKE];
   endproperty
   a_rsm: assert property (p_rsm)
      else $error("resume not recorded");

   property p_sof;
      @(posedge pclk) disable iff (!presetn)
      (ce && rise[2]) |=> pend_r[`UIRQ_BIT_SOF];
   endproperty
   a_sof: assert property (p_sof)
      else $error("frame start not recorded");

   property p_brst;
      @(posedge pclk) disable iff (!presetn)
      (ce && rise[3]) |=> pend_r[`UIRQ_BIT_BRST] && irq;
   endproperty
   a_brst: assert property (p_brst)
      else $error("bus reset end not recorded or masked");

   property p_clr;
      @(posedge pclk) disable iff (!presetn)
      (wr && sel_clr && pwdata[`UIRQ_BIT_SOF] && !rise[2]) |=>
         !pend_r[`UIRQ_BIT_SOF];
   endproperty
   a_clr: assert property (p_clr)
      else $error("clear write did not clear frame status");

   property p_wake_brst;
      @(posedge pclk) disable iff (!presetn)
      (ce && rise[3]) |=> pend_r[`UIRQ_BIT_WAKE];
   endproperty
   a_wake_brst: assert property (p_wake_brst)
      else $error("bus reset end did not set wakeup");

   // Only the flag owner may drop endpoint status, never the clear write
   property p_ep_kept;
      @(posedge pclk) disable iff (!presetn)
      (wr && sel_clr && ep_flags[4:0] != 5'h0) |=>
         pend_view[0] || ep_flags[4:0] == 5'h0;
   endproperty
   a_ep_kept: assert property (p_ep_kept)
      else $error("clear write dropped endpoint status");

   // Clock enable low must leave the mask, pending and idle registers untouched
   property p_frozen;
      @(posedge pclk) disable iff (!presetn)
      !ce |=> $stable(mask_r) && $stable(pend_r) && $stable(idle_r);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// ==== verilog/uirq_regs.svh ====
`ifndef UIRQ_REGS_SVH
`define UIRQ_REGS_SVH
// ==========================================
// Register offsets (byte addresses)
`define UIRQ_OFS_ENABLE 12'h010
`define UIRQ_OFS_DISABLE 12'h014
`define UIRQ_OFS_MASK 12'h018
`define UIRQ_OFS_PEND 12'h01C
`define UIRQ_OFS_CLEAR 12'h020
// ==========================================
// Field positions
`define UIRQ_BIT_SUSP 8
`define UIRQ_BIT_RSM 9
`define UIRQ_BIT_SOF 11
`define UIRQ_BIT_BRST 12
`define UIRQ_BIT_WAKE 13
`define UIRQ_EP_NUM 6
`define UIRQ_EP_FLAGS 5
// Maskable positions, event positions, forced-one position
`define UIRQ_MASK_VALID 32'h0000_2B3F
`define UIRQ_EVT_VALID 32'h0000_3B00
`define UIRQ_MASK_FORCED 32'h0000_1000
// ==========================================
// Reset values
`define UIRQ_MASK_RST 32'h0000_0200
`define UIRQ_PEND_RST 32'h0000_0000
// ==========================================
// Timing
`define UIRQ_IDLE_MS 3
`define UIRQ_CLK_KHZ 125000
`define UIRQ_IDLE_CYC (`UIRQ_IDLE_MS * `UIRQ_CLK_KHZ)
`define UIRQ_CNT_W 19
`endif

// ==== verilog/uirq_pkg.sv ====
`default_nettype none
package uirq_pkg;
   // Bus-side link state
   typedef enum logic [0:0] {
      UIRQ_ACTIVE = 1'b0,
      UIRQ_SUSPENDED = 1'b1
   } uirq_state_e;
   typedef logic [31:0] uirq_word_t;
endpackage
`default_nettype wire

// ==== verif/uirq_host_model.sv ====
`default_nettype none
// ==========================================
// Far-side bus model: line activity and event pins
module uirq_host_model (
   input wire logic pclk,
   output logic bus_activity,
   output logic bus_resume,
   output logic bus_sof,
   output logic bus_reset_done
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bus busy from the start so suspend does not fire early
   initial begin
      bus_activity = 1'b1;
      bus_resume = 1'b0;
      bus_sof = 1'b0;
      bus_reset_done = 1'b0;
   end
   // Held several cycles: very short pulses may be lost
   task pulse(input int kind, input int len);
      @(posedge pclk);
      case (kind)
         0: bus_sof <= 1'b1;
         1: bus_resume <= 1'b1;
         default: bus_reset_done <= 1'b1;
      endcase
      repeat (len) @(posedge pclk);
      bus_sof <= 1'b0;
      bus_resume <= 1'b0;
      bus_reset_done <= 1'b0;
   endtask
   task set_active(input logic on);
      @(posedge pclk);
      bus_activity <= on;
   endtask
endmodule
`default_nettype wire

// ==== verif/usb_device_irq_logic_tb.sv ====
`include "uirq_regs.svh"
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
   error_cnt++; $display("mismatch %s exp %h got %h", n, e, a); end end
module usb_device_irq_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ce = 1'b1;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic pready, pslverr, irq, suspend_mode, err;
   logic [29:0] ep_flags = '0;
   logic bus_activity, bus_resume, bus_sof, bus_reset_done;
   int error_cnt = 0, num_checks = 0;
   logic [31:0] evt_bits [3] = '{32'h0000_0800, 32'h0000_2200, 32'h0000_3000};
   // ==========================================
   // Clock, design and far side
   always #4 pclk = ~pclk;
   uirq_core #(.IDLE_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ep_flags(ep_flags), .bus_activity(bus_activity),
      .bus_resume(bus_resume), .bus_sof(bus_sof),
      .bus_reset_done(bus_reset_done), .irq(irq),
      .suspend_mode(suspend_mode));
   uirq_host_model host (.pclk(pclk), .bus_activity(bus_activity),
      .bus_resume(bus_resume), .bus_sof(bus_sof),
      .bus_reset_done(bus_reset_done));
   // ==========================================
   // Bus helpers
   task cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // Request held until pready is seen high, then released
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait limit here: the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      `CHK("prdata", e, q)
   endtask
   // ==========================================
   // Scenarios
   task t_mask();
      rd(`UIRQ_OFS_MASK, 32'h0000_1200);
      wr(`UIRQ_OFS_CLEAR, 32'h0000_3B00);
      rd(`UIRQ_OFS_PEND, 32'h0);
      wr(`UIRQ_OFS_ENABLE, 32'h0000_2B3F);
      rd(`UIRQ_OFS_MASK, 32'h0000_3B3F);
      wr(`UIRQ_OFS_DISABLE, 32'h0000_0A00);
      rd(`UIRQ_OFS_MASK, 32'h0000_313F);
      wr(`UIRQ_OFS_DISABLE, 32'h0);
      rd(`UIRQ_OFS_MASK, 32'h0000_313F);
      wr(`UIRQ_OFS_ENABLE, 32'h0000_0A00);
      wr(`UIRQ_OFS_DISABLE, 32'h0000_1000);
      rd(`UIRQ_OFS_MASK, 32'h0000_3B3F);
   endtask
   // Clear register must not touch endpoint bits
   task t_ep();
      for (int i = 0; i < 30; i++) begin
         ep_flags <= 30'(1) << i;
         wr(`UIRQ_OFS_CLEAR, 32'hFFFF_FFFF);
         rd(`UIRQ_OFS_PEND, 32'(1) << (i / 5));
         `CHK("irq", 1'b1, irq)
      end
      ep_flags <= '0;
      rd(`UIRQ_OFS_PEND, 32'h0);
   endtask
   task t_evt();
      for (int k = 0; k < 3; k++) begin
         host.pulse(k, 4 + 3 * k);
         cyc(6);
         rd(`UIRQ_OFS_PEND, evt_bits[k]);
         `CHK("irq", 1'b1, irq)
         wr(`UIRQ_OFS_CLEAR, 32'h0);
         rd(`UIRQ_OFS_PEND, evt_bits[k]);
         wr(`UIRQ_OFS_CLEAR, evt_bits[k]);
         rd(`UIRQ_OFS_PEND, 32'h0);
      end
      wr(`UIRQ_OFS_DISABLE, 32'h0000_0800);
      host.pulse(0, 4);
      cyc(6);
      `CHK("irq", 1'b0, irq)
      wr(`UIRQ_OFS_ENABLE, 32'h0000_0800);
      cyc(1);
      `CHK("irq", 1'b1, irq)
      wr(`UIRQ_OFS_CLEAR, 32'h0000_0800);
   endtask
   // Idle span shortened to 20 cycles for simulation
   task t_susp();
      host.set_active(1'b0);
      cyc(40);
      rd(`UIRQ_OFS_PEND, 32'h0000_0100);
      `CHK("suspend_mode", 1'b1, suspend_mode)
      host.set_active(1'b1);
      cyc(6);
      `CHK("suspend_mode", 1'b0, suspend_mode)
   endtask
   // Clock enable low stretches the access phase and freezes state
   task t_ce();
      @(posedge pclk);
      ce <= 1'b0;
      fork
         wr(`UIRQ_OFS_DISABLE, 32'h0000_0001);
         begin
            repeat (4) @(posedge pclk);
            `CHK("pready", 1'b0, pready)
            ce <= 1'b1;
         end
      join
      rd(`UIRQ_OFS_MASK, 32'h0000_3B3E);
   endtask
   task t_bad();
      apb(1'b0, 12'hFFC, '0);
      `CHK("pslverr", 1'b1, err)
      `CHK("prdata", 32'h0, q)
   endtask
   // ==========================================
   // Verdict and run control
   task final_report();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Whole run is a few hundred cycles; this is far beyond it
   initial begin
      #200000;
      error_cnt++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("irq", 1'b0, irq)
      t_mask();
      t_ep();
      t_evt();
      t_susp();
      t_ce();
      t_bad();
      final_report();
   end
endmodule
`default_nettype wire
